// ---- logic/rafo_axil_slave.sv ----
// AXI4-Lite slave: turns bus transfers into register strobes.
// Assumes single clock, synchronous active-low reset, index = addr / 4.
`timescale 1ns/100ps
`default_nettype none
module rafo_axil_slave
  import rafo_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Register strobes
  output logic wr_en,
  output logic [7:0] wr_idx,
  output logic [7:0] wr_data,
  output logic wr_lane0,
  input wire logic wr_hit,
  output logic rd_en,
  output logic [7:0] rd_idx,
  input wire logic [7:0] rd_data,
  input wire logic rd_hit
);
  if (ADDR_W < 10) begin : g_chk
    $error("rafo_axil_slave: ADDR_W must be at least 10");
  end

  // Word index of a byte address
  function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
    return a[9:2];
  endfunction

  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] aw_idx_reg;
  logic [7:0] w_data_reg;
  logic w_lane0_reg;

  // Each channel accepted on its own, held until the response goes out
  assign s_awready = !aw_full_reg && !s_bvalid;
  assign s_wready = !w_full_reg && !s_bvalid;
  assign wr_en = aw_full_reg && w_full_reg && !s_bvalid;
  assign wr_idx = aw_idx_reg;
  assign wr_data = w_data_reg;
  assign wr_lane0 = w_lane0_reg;

  // Write address and data capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_idx_reg <= 8'h00;
      w_data_reg <= 8'h00;
      w_lane0_reg <= 1'b0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_full_reg <= 1'b1;
        aw_idx_reg <= idx_of(s_awaddr);
      end else if (wr_en) begin
        aw_full_reg <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_wdata[7:0];
        w_lane0_reg <= s_wstrb[0];
      end else if (wr_en) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_bvalid <= 1'b0;
      s_bresp <= RAFO_OKAY;
    end else if (wr_en) begin
      s_bvalid <= 1'b1;
      s_bresp <= wr_hit ? RAFO_OKAY : RAFO_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // Read: one cycle from address to data
  assign s_arready = !s_rvalid;
  assign rd_en = s_arvalid && s_arready;
  assign rd_idx = idx_of(s_araddr);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= RAFO_OKAY;
    end else if (rd_en) begin
      s_rvalid <= 1'b1;
      s_rdata <= {24'h00_0000, rd_data};
      s_rresp <= rd_hit ? RAFO_OKAY : RAFO_SLVERR;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
endmodule // rafo_axil_slave
`default_nettype wire

// ---- logic/rafo_defines.svh ----
// Constants of the receive modem register bank: indices, fields, resets.
// Assumes byte address = 4 x register index on a 32-bit register bus.
`ifndef RAFO_DEFINES_SVH
`define RAFO_DEFINES_SVH

// Register indices
`define RAFO_IDX_NOW 8'h26
`define RAFO_IDX_THR 8'h27
`define RAFO_IDX_ANT1 8'h28
`define RAFO_IDX_ANT2 8'h29
`define RAFO_IDX_LIM 8'h2a
`define RAFO_IDX_AFCH 8'h2b
`define RAFO_IDX_OOK1 8'h2c
`define RAFO_IDX_OOK2 8'h2d
`define RAFO_IDX_ISTS 8'h40
`define RAFO_IDX_IMSK 8'h41

// Reset values
`define RAFO_RST_NOW 8'h00
`define RAFO_RST_THR 8'h1e
`define RAFO_RST_ANT 8'h00
`define RAFO_RST_LIM 8'h2a
`define RAFO_RST_AFC 10'h000
`define RAFO_RST_OOK1 6'h2c
`define RAFO_RST_OOK2 8'h00
`define RAFO_RST_IRQ 2'h0
`define RAFO_RST_GAIN 8'h00

// Field positions in the first counter register
`define RAFO_BIT_FRZ 5
`define RAFO_BIT_PEAK 4
`define RAFO_BIT_MA 3

// Interrupt status bits
`define RAFO_IRQ_THR 0
`define RAFO_IRQ_AFC 1

`endif

// ---- logic/rafo_pkg.sv ----
// Types shared by the register bank and its bus slave.
// Assumes nothing beyond a SystemVerilog compiler.
package rafo_pkg;
  // AXI4-Lite response codes
  typedef enum logic [1:0] {
    RAFO_OKAY = 2'b00,
    RAFO_SLVERR = 2'b10
  } rafo_resp_t;
endpackage

// ---- logic/rafo_regbank.sv ----
// Receive modem register bank: signal strength, frequency correction,
// on-off-keying controls, interrupt status and mask, AXI4-Lite access.
// Assumes modem strobes are synchronous one-cycle pulses on clk.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "rafo_defines.svh"

// Operation
// - Present strength is an 8-bit read-only value, zero after reset.
// - Strength above the threshold (reset 30) raises the strength interrupt.
// - Strength seen on the first antenna is kept in its own read-only register.
// - Strength seen on the second antenna is kept separately, zero after reset.
// - Upper eight bits of the 10-bit correction read from their own register.
// - Correction latched once per reception, at sync found, then held.
// - Low two correction bits read in bits 7:6 of first counter register.
// - Freeze bit holds the on-off-keying gain control at its setting.
// - Peak detector enabled only while its control bit is high.
// - Moving-average block enabled only while its control bit is high.
// - Counter bits 10:8 sit in bits 2:0 of first counter register.
// - Counter bits 7:0 sit in the second counter register, read-write.
module rafo_regbank
  import rafo_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Strength measurement
  input wire logic [7:0] rssi_in,
  input wire logic rssi_valid,
  input wire logic div_capture,
  input wire logic div_ant_sel,
  // Frequency correction
  input wire logic [9:0] afc_corr_in,
  input wire logic rx_start,
  input wire logic sync_found,
  // Gain control
  input wire logic [7:0] agc_gain_in,
  output logic [7:0] agc_gain_out,
  // Demodulator controls
  output logic [7:0] afc_limit,
  output logic ook_agc_freeze,
  output logic peak_det_en,
  output logic ma_en,
  output logic [10:0] ook_count,
  // Interrupt
  output logic irq
);
  if (ADDR_W < 10) begin : g_chk
    $error("rafo_regbank: ADDR_W must be at least 10");
  end

  // Register index is decoded by the bank
  function automatic logic is_mapped(input logic [7:0] idx);
    return (idx >= `RAFO_IDX_NOW && idx <= `RAFO_IDX_OOK2) ||
           idx == `RAFO_IDX_ISTS || idx == `RAFO_IDX_IMSK;
  endfunction

  logic wr_en;
  logic [7:0] wr_idx;
  logic [7:0] wr_data;
  logic wr_lane0;
  logic wr_ok;
  logic rd_en;
  logic [7:0] rd_idx;
  logic [7:0] rd_data;

  logic [7:0] strength_now_reg;
  logic [7:0] threshold_reg;
  logic [7:0] antenna_one_reg;
  logic [7:0] antenna_two_level_reg;
  logic [7:0] limit_reg;
  logic [9:0] afc_reg;
  logic afc_taken_reg;
  logic [5:0] ook_ctrl_reg;
  logic [7:0] ook_low_reg;
  logic [1:0] irq_sts_reg;
  logic [1:0] irq_sts_next;
  logic [1:0] irq_msk_reg;
  logic [7:0] gain_hold_reg;
  logic [1:0] irq_event;

  rafo_axil_slave #(
    .ADDR_W(ADDR_W)
  ) u_bus (
    .clk(clk),
    .rst_n(rst_n),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_lane0(wr_lane0),
    .wr_hit(is_mapped(wr_idx)),
    .rd_en(rd_en),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_hit(is_mapped(rd_idx))
  );

  // Only byte lane 0 carries the 8-bit registers
  assign wr_ok = wr_en && wr_lane0;

  // Present strength follows each measurement
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strength_now_reg <= `RAFO_RST_NOW;
    end else if (rssi_valid) begin
      strength_now_reg <= rssi_in;
    end
  end

  // Diversity captures per antenna
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      antenna_one_reg <= `RAFO_RST_ANT;
      antenna_two_level_reg <= `RAFO_RST_ANT;
    end else if (div_capture) begin
      if (!div_ant_sel) begin
        antenna_one_reg <= rssi_in;
      end else begin
        antenna_two_level_reg <= rssi_in;
      end
    end
  end

  // Correction latched at first sync of a reception
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      afc_reg <= `RAFO_RST_AFC;
      afc_taken_reg <= 1'b0;
    end else if (rx_start) begin
      afc_taken_reg <= 1'b0;
    end else if (sync_found && !afc_taken_reg) begin
      afc_reg <= afc_corr_in;
      afc_taken_reg <= 1'b1;
    end
  end

  // Software-written settings
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      threshold_reg <= `RAFO_RST_THR;
      limit_reg <= `RAFO_RST_LIM;
      ook_ctrl_reg <= `RAFO_RST_OOK1;
      ook_low_reg <= `RAFO_RST_OOK2;
      irq_msk_reg <= `RAFO_RST_IRQ;
    end else if (wr_ok) begin
      unique case (wr_idx)
        `RAFO_IDX_THR: threshold_reg <= wr_data;
        `RAFO_IDX_LIM: limit_reg <= wr_data;
        `RAFO_IDX_OOK1: ook_ctrl_reg <= wr_data[5:0];
        `RAFO_IDX_OOK2: ook_low_reg <= wr_data;
        `RAFO_IDX_IMSK: irq_msk_reg <= wr_data[1:0];
        default: ;
      endcase
    end
  end

  // Events: strength above threshold, correction latched
  assign irq_event[`RAFO_IRQ_THR] = strength_now_reg > threshold_reg;
  assign irq_event[`RAFO_IRQ_AFC] = sync_found && !afc_taken_reg && !rx_start;

  // Sticky status, write one to clear, set wins over clear
  always_comb begin
    irq_sts_next = irq_sts_reg;
    if (wr_ok && wr_idx == `RAFO_IDX_ISTS) begin
      irq_sts_next = irq_sts_next & ~wr_data[1:0];
    end
    irq_sts_next = irq_sts_next | irq_event;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_sts_reg <= `RAFO_RST_IRQ;
    end else begin
      irq_sts_reg <= irq_sts_next;
    end
  end

  assign irq = |(irq_sts_reg & irq_msk_reg);

  // Gain control hold while frozen
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gain_hold_reg <= `RAFO_RST_GAIN;
    end else if (!ook_ctrl_reg[`RAFO_BIT_FRZ]) begin
      gain_hold_reg <= agc_gain_in;
    end
  end

  // Demodulator control outputs
  assign agc_gain_out = gain_hold_reg;
  assign afc_limit = limit_reg;
  assign ook_agc_freeze = ook_ctrl_reg[`RAFO_BIT_FRZ];
  assign peak_det_en = ook_ctrl_reg[`RAFO_BIT_PEAK];
  assign ma_en = ook_ctrl_reg[`RAFO_BIT_MA];
  assign ook_count = {ook_ctrl_reg[2:0], ook_low_reg};

  // Read mux, free of side effects
  always_comb begin
    unique case (rd_idx)
      `RAFO_IDX_NOW: rd_data = strength_now_reg;
      `RAFO_IDX_THR: rd_data = threshold_reg;
      `RAFO_IDX_ANT1: rd_data = antenna_one_reg;
      `RAFO_IDX_ANT2: rd_data = antenna_two_level_reg;
      `RAFO_IDX_LIM: rd_data = limit_reg;
      `RAFO_IDX_AFCH: rd_data = afc_reg[9:2];
      `RAFO_IDX_OOK1: rd_data = {afc_reg[1:0], ook_ctrl_reg};
      `RAFO_IDX_OOK2: rd_data = ook_low_reg;
      `RAFO_IDX_ISTS: rd_data = {6'h00, irq_sts_reg};
      `RAFO_IDX_IMSK: rd_data = {6'h00, irq_msk_reg};
      default: rd_data = 8'h00;
    endcase
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_first_sync;
    sync_found && !afc_taken_reg && !rx_start;
  endsequence

  sequence s_held_rx;
    afc_taken_reg && !rx_start;
  endsequence

  strength_now_a: assert property (
    rssi_valid |=> strength_now_reg == $past(rssi_in))
    else $error("present strength not updated from measurement");

  thr_irq_a: assert property (
    (strength_now_reg > threshold_reg) |=> irq_sts_reg[`RAFO_IRQ_THR])
    else $error("threshold crossing did not set status");

  ant_one_a: assert property (
    div_capture && !div_ant_sel |=>
      antenna_one_reg == $past(rssi_in) && $stable(antenna_two_level_reg))
    else $error("first antenna capture wrong");

  ant_two_a: assert property (
    div_capture && div_ant_sel |=>
      antenna_two_level_reg == $past(rssi_in) && $stable(antenna_one_reg))
    else $error("second antenna capture wrong");

  afc_high_a: assert property (
    rd_en && rd_idx == `RAFO_IDX_AFCH |=> s_rdata[7:0] == $past(afc_reg[9:2]))
    else $error("correction high bits misread");

  afc_latch_a: assert property (
    s_first_sync |=> afc_reg == $past(afc_corr_in) ##1 (afc_taken_reg || $past(rx_start)))
    else $error("correction not latched at sync");

  afc_hold_a: assert property (
    s_held_rx |=> $stable(afc_reg))
    else $error("correction changed after latch");

  afc_low_a: assert property (
    rd_en && rd_idx == `RAFO_IDX_OOK1 |=> s_rdata[7:6] == $past(afc_reg[1:0]))
    else $error("correction low bits misread");

  gain_freeze_a: assert property (
    $past(rst_n) && ook_agc_freeze && $past(ook_agc_freeze) |-> $stable(agc_gain_out))
    else $error("gain moved while frozen");

  ctrl_write_a: assert property (
    wr_ok && wr_idx == `RAFO_IDX_OOK1 |=>
      peak_det_en == $past(wr_data[4]) && ma_en == $past(wr_data[3]) &&
      ook_agc_freeze == $past(wr_data[5]))
    else $error("control bits not written");

  ma_read_a: assert property (
    rd_en && rd_idx == `RAFO_IDX_OOK1 |=> s_rdata[3] == $past(ma_en))
    else $error("moving-average enable misread");

  cnt_high_a: assert property (
    wr_ok && wr_idx == `RAFO_IDX_OOK1 |=> ook_count[10:8] == $past(wr_data[2:0]))
    else $error("counter high bits not written");

  cnt_low_a: assert property (
    wr_ok && wr_idx == `RAFO_IDX_OOK2 |=>
      ook_count[7:0] == $past(wr_data) && $stable(ook_count[10:8]))
    else $error("counter low bits not written");

  read_quiet_a: assert property (
    rd_en && !wr_en |=> ($past(irq_sts_reg) & ~irq_sts_reg) == 2'h0)
    else $error("read cleared a pending interrupt");

  // Latch event, rearm priority, read-only contents
  afc_irq_a: assert property (
    s_first_sync |=> irq_sts_reg[`RAFO_IRQ_AFC])
    else $error("correction latch did not set status");

  rearm_wins_a: assert property (
    sync_found && rx_start |=> !afc_taken_reg && $stable(afc_reg))
    else $error("sync latched although reception restarted");

  now_ro_a: assert property (
    wr_ok && wr_idx == `RAFO_IDX_NOW && !rssi_valid |=> $stable(strength_now_reg))
    else $error("present strength changed by a bus write");

  afc_ro_a: assert property (
    wr_ok && wr_idx == `RAFO_IDX_AFCH && !sync_found |=> $stable(afc_reg))
    else $error("correction changed by a bus write");

  read_keeps_a: assert property (
    rd_en && !rssi_valid && !sync_found |=>
      $stable(strength_now_reg) && $stable(afc_reg))
    else $error("read changed strength or correction");
endmodule // rafo_regbank
`default_nettype wire

// ---- verification/rafo_regbank_tb_top.sv ----
// Self-checking bench for the receive modem register bank.
// Assumes the bank answers AXI4-Lite on a single 50 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`include "rafo_defines.svh"
module rafo_regbank_tb_top
  import rafo_pkg::*;
;
  typedef struct {
    logic [9:0] addr;
    logic wr;
    logic [3:0] strb;
    logic [7:0] wd;
    logic [31:0] exp;
    logic [1:0] resp;
  } rafo_row_t;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [9:0] awaddr = 10'h000, araddr = 10'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [7:0] rssi_in = 8'h00, agc_gain_in = 8'h00;
  logic rssi_valid = 1'b0, div_capture = 1'b0, div_ant_sel = 1'b0;
  logic [9:0] afc_corr_in = 10'h000;
  logic rx_start = 1'b0, sync_found = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic [7:0] agc_gain_out, afc_limit;
  logic ook_agc_freeze, peak_det_en, ma_en;
  logic [10:0] ook_count;
  int n_mismatch = 0;
  int compares = 0;
  rafo_row_t rows[$];
  logic [31:0] d;
  logic [1:0] r;

  // Free-running 50 MHz clock
  always #10 clk = ~clk;

  rafo_regbank #(.ADDR_W(10)) DUT (
    .clk(clk), .rst_n(rst_n),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(s_awready),
    .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(rready),
    .rssi_in(rssi_in), .rssi_valid(rssi_valid), .div_capture(div_capture),
    .div_ant_sel(div_ant_sel), .afc_corr_in(afc_corr_in), .rx_start(rx_start),
    .sync_found(sync_found), .agc_gain_in(agc_gain_in), .agc_gain_out(agc_gain_out),
    .afc_limit(afc_limit), .ook_agc_freeze(ook_agc_freeze), .peak_det_en(peak_det_en),
    .ma_en(ma_en), .ook_count(ook_count), .irq(irq)
  );

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic rafo_row_t mk(input logic [7:0] i, input logic w, input logic [3:0] s,
                                   input logic [7:0] wd, input logic [7:0] e,
                                   input logic [1:0] rs);
    mk = '{{i, 2'b00}, w, s, wd, {24'h0, e}, rs};
  endfunction

  // Bus write: both channels offered together, each released when taken
  task automatic axw(input logic [9:0] a, input logic [7:0] dv, input logic [3:0] st,
                     output logic [1:0] rs);
    logic ad, wdn, aok, wok;
    ad = 1'b0;
    wdn = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, dv};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wdn)) begin
      @(negedge clk);
      aok = awvalid && s_awready;
      wok = wvalid && s_wready;
      @(posedge clk);
      if (aok) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (wok) begin
        wvalid <= 1'b0;
        wdn = 1'b1;
      end
    end
    do begin
      @(negedge clk);
      rs = s_bresp;
      aok = s_bvalid;
      @(posedge clk);
    end while (!aok);
    bready <= 1'b0;
  endtask

  // Bus read: address held until taken, data taken with rvalid
  task automatic axr(input logic [9:0] a, output logic [31:0] dv, output logic [1:0] rs);
    logic ok;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ok = s_arready;
      @(posedge clk);
    end while (!ok);
    arvalid <= 1'b0;
    do begin
      @(negedge clk);
      dv = s_rdata;
      rs = s_rresp;
      ok = s_rvalid;
      @(posedge clk);
    end while (!ok);
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] dv);
    logic [1:0] rs;
    axw({i, 2'b00}, dv, 4'hf, rs);
  endtask

  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    logic [31:0] dv;
    logic [1:0] rs;
    axr({i, 2'b00}, dv, rs);
    chk(dv, {24'h0, e});
  endtask

  // One-cycle modem strobes: 0 level, 1 capture, 2 rearm, 3 sync, 4 rearm with sync
  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: rssi_valid <= 1'b1;
      1: div_capture <= 1'b1;
      2: rx_start <= 1'b1;
      3: sync_found <= 1'b1;
      default: begin
        rx_start <= 1'b1;
        sync_found <= 1'b1;
      end
    endcase
    @(posedge clk);
    {rssi_valid, div_capture, rx_start, sync_found} <= 4'h0;
  endtask

  task automatic wrap_up();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end

  // Main sequence
  initial begin
    rows = '{mk(`RAFO_IDX_NOW, 0, 4'hf, 0, 8'h00, RAFO_OKAY), mk(`RAFO_IDX_THR, 0, 4'hf, 0, 8'h1e, RAFO_OKAY),
             mk(`RAFO_IDX_ANT1, 0, 4'hf, 0, 8'h00, RAFO_OKAY), mk(`RAFO_IDX_ANT2, 0, 4'hf, 0, 8'h00, RAFO_OKAY),
             mk(`RAFO_IDX_LIM, 0, 4'hf, 0, 8'h2a, RAFO_OKAY), mk(`RAFO_IDX_AFCH, 0, 4'hf, 0, 8'h00, RAFO_OKAY),
             mk(`RAFO_IDX_OOK1, 0, 4'hf, 0, 8'h2c, RAFO_OKAY), mk(`RAFO_IDX_OOK2, 0, 4'hf, 0, 8'h00, RAFO_OKAY),
             mk(`RAFO_IDX_ISTS, 0, 4'hf, 0, 8'h00, RAFO_OKAY), mk(`RAFO_IDX_IMSK, 0, 4'hf, 0, 8'h00, RAFO_OKAY),
             mk(`RAFO_IDX_THR, 1, 4'hf, 8'h55, 8'h55, RAFO_OKAY), mk(`RAFO_IDX_LIM, 1, 4'hf, 8'h81, 8'h81, RAFO_OKAY),
             mk(`RAFO_IDX_OOK2, 1, 4'hf, 8'ha5, 8'ha5, RAFO_OKAY), mk(`RAFO_IDX_OOK1, 1, 4'hf, 8'hff, 8'h3f, RAFO_OKAY),
             mk(`RAFO_IDX_NOW, 1, 4'hf, 8'hff, 8'h00, RAFO_OKAY), mk(`RAFO_IDX_ANT2, 1, 4'hf, 8'hff, 8'h00, RAFO_OKAY),
             mk(`RAFO_IDX_AFCH, 1, 4'hf, 8'hff, 8'h00, RAFO_OKAY), mk(`RAFO_IDX_THR, 1, 4'h0, 8'h00, 8'h55, RAFO_OKAY),
             mk(8'hff, 1, 4'hf, 8'h12, 8'h00, RAFO_SLVERR)};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axw(rows[i].addr, rows[i].wd, rows[i].strb, r);
        chk({30'h0, r}, {30'h0, rows[i].resp});
      end
      axr(rows[i].addr, d, r);
      chk(d, rows[i].exp);
      chk({30'h0, r}, {30'h0, rows[i].resp});
    end
    chk({21'h0, ook_count}, 32'h7a5);
    chk({24'h0, afc_limit}, 32'h81);
    // Counter for 1.2 kbps without Manchester: 1500 / 1.2 = 1250
    wr(`RAFO_IDX_OOK2, 8'he2);
    wr(`RAFO_IDX_OOK1, 8'h04);
    chk({21'h0, ook_count}, 32'h4e2);
    // Each control bit alone drives its own enable
    for (int b = 3; b < 6; b++) begin
      wr(`RAFO_IDX_OOK1, 8'h01 << b);
      chk({29'h0, ook_agc_freeze, peak_det_en, ma_en}, 32'h1 << (b - 3));
    end
    // Gain follows while unfrozen, then holds once frozen
    wr(`RAFO_IDX_OOK1, 8'h08);
    agc_gain_in <= 8'h5a;
    repeat (3) @(posedge clk);
    chk({24'h0, agc_gain_out}, 32'h5a);
    wr(`RAFO_IDX_OOK1, 8'h20);
    agc_gain_in <= 8'h11;
    repeat (3) @(posedge clk);
    chk({24'h0, agc_gain_out}, 32'h5a);
    // Threshold is strict, masked off, then raised and re-set while above
    wr(`RAFO_IDX_THR, 8'h40);
    rssi_in <= 8'h40;
    pulse(0);
    wr(`RAFO_IDX_ISTS, 8'h03);
    rdc(`RAFO_IDX_NOW, 8'h40);
    rdc(`RAFO_IDX_ISTS, 8'h00);
    rssi_in <= 8'h41;
    pulse(0);
    rdc(`RAFO_IDX_ISTS, 8'h01);
    chk({31'h0, irq}, 32'h0);
    wr(`RAFO_IDX_IMSK, 8'h01);
    chk({31'h0, irq}, 32'h1);
    rdc(`RAFO_IDX_NOW, 8'h41);
    wr(`RAFO_IDX_ISTS, 8'h01);
    rdc(`RAFO_IDX_ISTS, 8'h01);
    rssi_in <= 8'h10;
    pulse(0);
    wr(`RAFO_IDX_ISTS, 8'h01);
    rdc(`RAFO_IDX_ISTS, 8'h00);
    chk({31'h0, irq}, 32'h0);
    // Per-antenna captures
    rssi_in <= 8'h33;
    pulse(1);
    div_ant_sel <= 1'b1;
    rssi_in <= 8'h77;
    pulse(1);
    rdc(`RAFO_IDX_ANT1, 8'h33);
    rdc(`RAFO_IDX_ANT2, 8'h77);
    rdc(`RAFO_IDX_NOW, 8'h10);
    // Correction latched once per reception
    afc_corr_in <= 10'h2d6;
    pulse(2);
    pulse(3);
    rdc(`RAFO_IDX_AFCH, 8'hb5);
    rdc(`RAFO_IDX_OOK1, 8'ha0);
    rdc(`RAFO_IDX_ISTS, 8'h02);
    wr(`RAFO_IDX_IMSK, 8'h02);
    chk({31'h0, irq}, 32'h1);
    afc_corr_in <= 10'h0ff;
    pulse(3);
    rdc(`RAFO_IDX_AFCH, 8'hb5);
    pulse(4);
    rdc(`RAFO_IDX_AFCH, 8'hb5);
    pulse(3);
    rdc(`RAFO_IDX_AFCH, 8'h3f);
    rdc(`RAFO_IDX_OOK1, 8'he0);
    // Reset in mid-run restores defaults
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`RAFO_IDX_THR, 8'h1e);
    rdc(`RAFO_IDX_AFCH, 8'h00);
    rdc(`RAFO_IDX_OOK1, 8'h2c);
    wrap_up();
  end
endmodule // rafo_regbank_tb_top
`default_nettype wire
